// [mcsr_arb_route.sv]
`timescale 1ns/10ps
module mcsr_arb_route (
	input wire logic dual_port,
	input wire logic arbiter_pins_configured,
	input wire logic [2:0] shared_master_owner,
	input wire logic [2:0] ext_req,
	output logic [2:0] port1_req,
	output logic [2:0] port2_req
);
	genvar i;
	generate
		for (i = 0; i < 3; i++)
		begin : g_pair
			logic live;
			assign live = ext_req[i] & (arbiter_pins_configured | ~dual_port);
			assign port1_req[i] = live & ~(dual_port & shared_master_owner[i]);
			assign port2_req[i] = live & dual_port & shared_master_owner[i];
		end
	endgenerate
endmodule

// [mcsr_params.svh]
`ifndef MCSR_PARAMS_SVH
`define MCSR_PARAMS_SVH
`define MCSR_ADDR_W 12
`define MCSR_OFFSET 12'h400
`define MCSR_DEV_LSB 24
`define MCSR_REV_LSB 16
`define MCSR_PDE_BIT 15
`define MCSR_PCS_LSB 12
`define MCSR_ZBP_BIT 11
`define MCSR_ELC_LSB 8
`define MCSR_P1B_BIT 7
`define MCSR_P2B_BIT 6
`define MCSR_APC_BIT 3
`define MCSR_OWN_LSB 0
`define MCSR_RESP_OKAY 2'h0
`define MCSR_RESP_SLVERR 2'h2
`endif

// [mcsr_pci_agent.sv]
`timescale 1ns/10ps
module mcsr_pci_agent (
	input wire logic aclk,
	output logic eeprom_load_valid,
	output logic [31:0] eeprom_load_data,
	output logic powerup_boot_select,
	output logic [1:0] access,
	output logic [1:0] target_mem,
	output logic [2:0] ext_req
);
	initial
	begin
		eeprom_load_valid = 1'b0;
		eeprom_load_data = 32'h0;
		powerup_boot_select = 1'b0;
		access = 2'h0;
		target_mem = 2'h0;
		ext_req = 3'h0;
	end
	// PCI side traffic, request lines and boot strap
	task automatic drive(input logic [1:0] a, input logic [1:0] m,
		input logic [2:0] q, input logic boot);
		@(posedge aclk);
		access <= a;
		target_mem <= m;
		ext_req <= q;
		powerup_boot_select <= boot;
	endtask
	// Image load sets block bits and owners from the image
	task automatic load(input logic [31:0] img);
		@(posedge aclk);
		eeprom_load_valid <= 1'b1;
		eeprom_load_data <= img;
		@(posedge aclk);
		eeprom_load_valid <= 1'b0;
		eeprom_load_data <= ~img;
	endtask
endmodule

// [mcsr_pkg.sv]
package mcsr_pkg;
	typedef enum logic [1:0]
	{
		MCSR_LOAD_NONE = 2'h0,
		MCSR_LOAD_SHORT = 2'h1,
		MCSR_LOAD_LONG = 2'h2,
		MCSR_LOAD_RSVD = 2'h3
	} mcsr_load_t;
	typedef enum logic [1:0]
	{
		MCSR_WR_IDLE = 2'b01,
		MCSR_WR_RESP = 2'b10
	} mcsr_wstate_t;
endpackage

// [mcsr_regs.sv]
// Summary of operation
// - Top bytes hold read-only maker device code and revision code.
// - Product data enable routes product data via primary port registers.
// - Three-bit read/write chip select names the product data EEPROM.
// - Zero base permit lets a zero base address count as valid.
// - Read-only load choice from first EEPROM byte: none, short, long.
// - Set access block retries that port's config and register accesses.
// - Target memory access never terminates while the block bit stays set.
// - Boot from PCI clears both access block bits automatically.
// - Arbiter pins configured is write-one-to-set; enables requests 7 to 5.
// - While unconfigured, dual-port external requests on lines 7 to 5 are ignored.
// - Owner bit 0 picks port-1 arbiter, 1 picks port-2 arbiter.
// - Owner bits 5, 6, 7 steer request/grant pairs 5, 6, 7.
// - Single-port variant: owners ignored, lines 7 to 5 go to port 1.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "mcsr_params.svh"
module mcsr_regs
	import mcsr_pkg::*;
#(
	parameter bit DUAL_PORT = 1'b1,
	parameter logic [7:0] MAKER_DEVICE_CODE = 8'h5a, // Arbitrary value
	parameter logic [7:0] REVISION_CODE = 8'h3c // Arbitrary value
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic eeprom_load_valid,
	input wire logic [31:0] eeprom_load_data,
	input wire logic powerup_boot_select,
	input wire logic port1_access,
	input wire logic port2_access,
	input wire logic port1_target_mem,
	input wire logic port2_target_mem,
	input wire logic [2:0] ext_req,
	output logic port1_retry,
	output logic port2_retry,
	output logic port1_target_hold,
	output logic port2_target_hold,
	output logic product_data_enable,
	output logic [2:0] product_data_chip_select,
	output logic zero_base_permit,
	output logic [2:0] port1_req,
	output logic [2:0] port2_req
);
	logic [1:0] eeprom_load_choice, next_eeprom_load_choice;
	logic port1_access_block, next_port1_access_block;
	logic port2_access_block, next_port2_access_block;
	logic arbiter_pins_configured, next_arbiter_pins_configured;
	logic [2:0] shared_master_owner, next_shared_master_owner;
	logic next_product_data_enable, next_zero_base_permit;
	logic [2:0] next_product_data_chip_select;
	logic boot_pci;
	logic [2:0] req_sync;
	logic aw_held, next_aw_held, w_held, next_w_held;
	logic [11:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	mcsr_wstate_t wstate, next_wstate;
	logic [1:0] bresp_q, next_bresp, next_rresp;
	logic next_rvalid, do_write, hit_w;
	logic [31:0] next_rdata, wmask, regval;

	mcsr_sync #(.WIDTH(1)) u_boot_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(powerup_boot_select),
		.sync_out(boot_pci)
	);
	mcsr_sync #(.WIDTH(3)) u_req_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(ext_req),
		.sync_out(req_sync)
	);
	mcsr_arb_route u_route (
		.dual_port(DUAL_PORT),
		.arbiter_pins_configured(arbiter_pins_configured),
		.shared_master_owner(shared_master_owner),
		.ext_req(req_sync),
		.port1_req(port1_req),
		.port2_req(port2_req)
	);

	// Register image
	always_comb
	begin
		regval = '0;
		regval[`MCSR_DEV_LSB +: 8] = MAKER_DEVICE_CODE;
		regval[`MCSR_REV_LSB +: 8] = REVISION_CODE;
		regval[`MCSR_PDE_BIT] = product_data_enable;
		regval[`MCSR_PCS_LSB +: 3] = product_data_chip_select;
		regval[`MCSR_ZBP_BIT] = zero_base_permit;
		regval[`MCSR_ELC_LSB +: 2] = eeprom_load_choice;
		regval[`MCSR_P1B_BIT] = port1_access_block;
		if (DUAL_PORT)
		begin
			regval[`MCSR_P2B_BIT] = port2_access_block;
			regval[`MCSR_APC_BIT] = arbiter_pins_configured;
			regval[`MCSR_OWN_LSB +: 3] = shared_master_owner;
		end
	end

	// Write channel
	always_comb
	begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_wstate = wstate;
		next_bresp = bresp_q;
		do_write = 1'b0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		case (wstate)
			MCSR_WR_IDLE:
			begin
				if (aw_held && w_held)
				begin
					do_write = 1'b1;
					next_aw_held = 1'b0;
					next_w_held = 1'b0;
					next_wstate = MCSR_WR_RESP;
					next_bresp = hit_w ? `MCSR_RESP_OKAY : `MCSR_RESP_SLVERR;
				end
			end
			MCSR_WR_RESP:
			begin
				if (s_axi_bready)
					next_wstate = MCSR_WR_IDLE;
			end
			default:
				next_wstate = MCSR_WR_IDLE;
		endcase
	end
	assign hit_w = aw_addr[11:2] == 10'(`MCSR_OFFSET >> 2);
	assign s_axi_awready = ~aw_held && wstate == MCSR_WR_IDLE;
	assign s_axi_wready = ~w_held && wstate == MCSR_WR_IDLE;
	assign s_axi_bvalid = wstate == MCSR_WR_RESP;
	assign s_axi_bresp = bresp_q;
	always_comb
	begin
		for (int b = 0; b < 4; b++)
			wmask[b*8 +: 8] = {8{w_strb[b] & do_write & hit_w}};
	end

	// Field updates: reset, then EEPROM load, then software
	always_comb
	begin
		next_eeprom_load_choice = eeprom_load_choice;
		next_product_data_enable = product_data_enable;
		next_product_data_chip_select = product_data_chip_select;
		next_zero_base_permit = zero_base_permit;
		next_port1_access_block = port1_access_block;
		next_port2_access_block = port2_access_block;
		next_arbiter_pins_configured = arbiter_pins_configured;
		next_shared_master_owner = shared_master_owner;
		if (eeprom_load_valid)
		begin
			next_eeprom_load_choice = eeprom_load_data[`MCSR_ELC_LSB +: 2];
			next_product_data_enable = eeprom_load_data[`MCSR_PDE_BIT];
			next_product_data_chip_select = eeprom_load_data[`MCSR_PCS_LSB +: 3];
			next_zero_base_permit = eeprom_load_data[`MCSR_ZBP_BIT];
			next_port1_access_block = eeprom_load_data[`MCSR_P1B_BIT];
			next_port2_access_block = eeprom_load_data[`MCSR_P2B_BIT];
			next_arbiter_pins_configured = eeprom_load_data[`MCSR_APC_BIT];
			next_shared_master_owner = eeprom_load_data[`MCSR_OWN_LSB +: 3];
		end
		else
		begin
			if (wmask[`MCSR_PDE_BIT])
				next_product_data_enable = w_data[`MCSR_PDE_BIT];
			if (wmask[`MCSR_PCS_LSB])
				next_product_data_chip_select = w_data[`MCSR_PCS_LSB +: 3];
			if (wmask[`MCSR_ZBP_BIT])
				next_zero_base_permit = w_data[`MCSR_ZBP_BIT];
			if (wmask[`MCSR_P1B_BIT] && w_data[`MCSR_P1B_BIT])
				next_port1_access_block = 1'b0;
			if (wmask[`MCSR_P2B_BIT] && w_data[`MCSR_P2B_BIT])
				next_port2_access_block = 1'b0;
			if (wmask[`MCSR_APC_BIT] && w_data[`MCSR_APC_BIT])
				next_arbiter_pins_configured = 1'b1;
			if (wmask[`MCSR_OWN_LSB])
				next_shared_master_owner = w_data[`MCSR_OWN_LSB +: 3];
		end
		if (boot_pci)
		begin
			next_port1_access_block = 1'b0;
			next_port2_access_block = 1'b0;
		end
	end

	// Read channel
	always_comb
	begin
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready)
			next_rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rvalid = 1'b1;
			if (s_axi_araddr[11:2] == 10'(`MCSR_OFFSET >> 2))
			begin
				next_rdata = regval;
				next_rresp = `MCSR_RESP_OKAY;
			end
			else
			begin
				next_rdata = '0;
				next_rresp = `MCSR_RESP_SLVERR;
			end
		end
	end
	assign s_axi_arready = ~s_axi_rvalid;

	// Access gating toward the PCI ports
	assign port1_retry = port1_access & port1_access_block;
	assign port2_retry = port2_access & port2_access_block & DUAL_PORT;
	assign port1_target_hold = port1_target_mem & port1_access_block;
	assign port2_target_hold = port2_target_mem & port2_access_block & DUAL_PORT;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			eeprom_load_choice <= MCSR_LOAD_NONE;
			product_data_enable <= 1'b0;
			product_data_chip_select <= 3'h0;
			zero_base_permit <= 1'b0;
			port1_access_block <= 1'b1;
			port2_access_block <= 1'b1;
			arbiter_pins_configured <= 1'b0;
			shared_master_owner <= 3'h0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			wstate <= MCSR_WR_IDLE;
			bresp_q <= `MCSR_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `MCSR_RESP_OKAY;
		end
		else
		begin
			eeprom_load_choice <= next_eeprom_load_choice;
			product_data_enable <= next_product_data_enable;
			product_data_chip_select <= next_product_data_chip_select;
			zero_base_permit <= next_zero_base_permit;
			port1_access_block <= next_port1_access_block;
			port2_access_block <= next_port2_access_block;
			arbiter_pins_configured <= next_arbiter_pins_configured;
			shared_master_owner <= next_shared_master_owner;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			wstate <= next_wstate;
			bresp_q <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	a_block_retry: assert property (@(posedge aclk) disable iff (!aresetn)
		port1_access && port1_access_block |-> port1_retry)
		else $error("port 1 access not retried while blocked");
	a_block_reset: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |-> port1_access_block)
		else $error("access block not set after reset");
	a_block_w1c: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && hit_w && w_strb[0] && w_data[`MCSR_P1B_BIT]
		&& !eeprom_load_valid |=> !port1_access_block)
		else $error("write one did not clear port 1 block");
	a_target_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		port1_target_mem && port1_access_block |-> port1_target_hold)
		else $error("target access terminated while blocked");
	a_boot_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		boot_pci |=> !port1_access_block && !port2_access_block)
		else $error("boot from PCI left block bits set");
	a_cfg_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		arbiter_pins_configured && !eeprom_load_valid
		|=> arbiter_pins_configured)
		else $error("configured bit cleared by software");
	a_req_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
		DUAL_PORT && !arbiter_pins_configured
		|-> port1_req == 3'h0 && port2_req == 3'h0)
		else $error("request passed while pins unconfigured");
	a_owner_route: assert property (@(posedge aclk) disable iff (!aresetn)
		DUAL_PORT && arbiter_pins_configured && req_sync[2]
		&& shared_master_owner[2] |-> port2_req[2] && !port1_req[2])
		else $error("master 7 not routed to port 2 arbiter");
	a_id_read: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `MCSR_OFFSET
		|=> s_axi_rdata[31:16] == {MAKER_DEVICE_CODE, REVISION_CODE})
		else $error("identity fields wrong on read");
endmodule

// [mcsr_sync.sv]
`timescale 1ns/10ps
module mcsr_sync #(
	parameter int WIDTH = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_sync_out;
	always_comb
	begin
		next_stage1 = async_in;
		next_sync_out = stage1;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stage1 <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1 <= next_stage1;
			sync_out <= next_sync_out;
		end
	end
endmodule

// [tb.sv]
`timescale 1ns/10ps
`include "mcsr_params.svh"
module tb
	import mcsr_pkg::*;
;
	localparam logic [31:0] ID = 32'h5a3c_0000;
	localparam logic [11:0] OFF = `MCSR_OFFSET;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h0;
	logic [11:0] araddr = 12'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, ld_v, boot;
	logic [1:0] bresp, rresp, acc, mem, retry, hold;
	logic [31:0] rdata, ld_d;
	logic [2:0] ext_req, cs, p1_req, p2_req;
	logic pde, zbp;
	int miscompares = 0;
	int n_compared = 0;
	always #50 aclk = ~aclk;
	mcsr_pci_agent mcsr_pci_agent_i (.aclk(aclk), .eeprom_load_valid(ld_v),
		.eeprom_load_data(ld_d), .powerup_boot_select(boot), .access(acc),
		.target_mem(mem), .ext_req(ext_req));
	// Identity codes are arbitrary
	mcsr_regs #(.DUAL_PORT(1'b1), .MAKER_DEVICE_CODE(8'h5a),
		.REVISION_CODE(8'h3c)) mcsr_regs_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .eeprom_load_valid(ld_v),
		.eeprom_load_data(ld_d), .powerup_boot_select(boot),
		.port1_access(acc[0]), .port2_access(acc[1]),
		.port1_target_mem(mem[0]), .port2_target_mem(mem[1]),
		.ext_req(ext_req), .port1_retry(retry[0]), .port2_retry(retry[1]),
		.port1_target_hold(hold[0]), .port2_target_hold(hold[1]),
		.product_data_enable(pde), .product_data_chip_select(cs),
		.zero_base_permit(zbp), .port1_req(p1_req), .port2_req(p2_req));
	logic [2:0] sp1_req, sp2_req;
	// Single-port variant shares every input with the dual-port one
	if (1'b1)
	begin : g_single
		mcsr_regs #(.DUAL_PORT(1'b0), .MAKER_DEVICE_CODE(8'h5a),
			.REVISION_CODE(8'h3c)) mcsr_regs_i (.aclk(aclk),
			.aresetn(aresetn), .s_axi_awaddr(awaddr),
			.s_axi_awvalid(awvalid), .s_axi_awready(),
			.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
			.s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
			.s_axi_bready(bready), .s_axi_araddr(araddr),
			.s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(),
			.s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
			.eeprom_load_valid(ld_v), .eeprom_load_data(ld_d),
			.powerup_boot_select(boot), .port1_access(acc[0]),
			.port2_access(acc[1]), .port1_target_mem(mem[0]),
			.port2_target_mem(mem[1]), .ext_req(ext_req),
			.port1_retry(), .port2_retry(), .port1_target_hold(),
			.port2_target_hold(), .product_data_enable(),
			.product_data_chip_select(), .zero_base_permit(),
			.port1_req(sp1_req), .port2_req(sp2_req));
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ha, hw;
		logic b = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b)
		begin
			@(negedge aclk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			b = bvalid;
			if (b)
				check(bresp, er);
			@(posedge aclk);
			if (ha)
				awvalid <= 1'b0;
			if (hw)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic ha;
		logic b = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!b)
		begin
			@(negedge aclk);
			ha = arvalid && arready;
			b = rvalid;
			if (b)
				check({rresp, rdata}, {er, ed});
			@(posedge aclk);
			if (ha)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask
	task automatic t_reset;
		rd(OFF, ID | 32'hc0, `MCSR_RESP_OKAY);
		mcsr_pci_agent_i.drive(2'b11, 2'b11, 3'h0, 1'b0);
		@(negedge aclk);
		check({retry, hold}, 4'hf);
		check({pde, cs, zbp}, 5'h00);
	endtask
	task automatic t_fields;
		wr(OFF, 32'hffff_ff30, `MCSR_RESP_OKAY);
		rd(OFF, ID | 32'hf8c0, `MCSR_RESP_OKAY);
		@(negedge aclk);
		check({pde, cs, zbp}, 5'h1f);
		wr(OFF, 32'h5000, `MCSR_RESP_OKAY);
		rd(OFF, ID | 32'h50c0, `MCSR_RESP_OKAY);
		@(negedge aclk);
		check({pde, cs, zbp}, 5'h0a);
	endtask
	task automatic t_block;
		wr(OFF, 32'h5080, `MCSR_RESP_OKAY);
		@(negedge aclk);
		check({retry, hold}, 4'ha);
		rd(OFF, ID | 32'h5040, `MCSR_RESP_OKAY);
		wr(OFF, 32'h5040, `MCSR_RESP_OKAY);
		@(negedge aclk);
		check({retry, hold}, 4'h0);
	endtask
	task automatic t_arb;
		mcsr_pci_agent_i.drive(2'b00, 2'b00, 3'h7, 1'b0);
		wr(OFF, 32'h5006, `MCSR_RESP_OKAY);
		@(negedge aclk);
		check({p2_req, p1_req}, 6'h00);
		check({sp2_req, sp1_req}, {3'b000, 3'b111});
		wr(OFF, 32'h500e, `MCSR_RESP_OKAY);
		rd(OFF, ID | 32'h500e, `MCSR_RESP_OKAY);
		@(negedge aclk);
		check({p2_req, p1_req}, {3'b110, 3'b001});
		wr(OFF, 32'h5001, `MCSR_RESP_OKAY);
		rd(OFF, ID | 32'h5009, `MCSR_RESP_OKAY);
		@(negedge aclk);
		check({p2_req, p1_req}, {3'b001, 3'b110});
	endtask
	task automatic t_unmapped;
		wr(12'h404, 32'h0, `MCSR_RESP_SLVERR);
		rd(12'h404, 32'h0, `MCSR_RESP_SLVERR);
		rd(OFF, ID | 32'h5009, `MCSR_RESP_OKAY);
	endtask
	task automatic t_load;
		logic [31:0] img;
		for (int k = 0; k < 4; k++)
		begin
			img = {16'h0, 6'b101000, 2'(k), 8'hc5};
			mcsr_pci_agent_i.load(img);
			rd(OFF, ID | img, `MCSR_RESP_OKAY);
		end
		mcsr_pci_agent_i.drive(2'b11, 2'b11, 3'h0, 1'b1);
		repeat (4) @(posedge aclk);
		rd(OFF, ID | 32'ha305, `MCSR_RESP_OKAY);
		@(negedge aclk);
		check({retry, hold}, 4'h0);
		mcsr_pci_agent_i.drive(2'b00, 2'b00, 3'h0, 1'b0);
	endtask
	task automatic close_out;
		if (miscompares == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_fields;
		t_block;
		t_arb;
		t_unmapped;
		t_load;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFF, ID | 32'hc0, `MCSR_RESP_OKAY);
		close_out;
	end
	initial
	begin
		#2000000;
		miscompares++;
		close_out;
	end
endmodule
